// *** include/tw_defines.svh ***
// Register addresses, field positions, reset values and status codes.
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH
`define TW_ADDR_CTRL 8'h93
`define TW_ADDR_STAT 8'h94
`define TW_ADDR_DATA 8'h95
`define TW_ADDR_OWN 8'h96
`define TW_B_CR2 7
`define TW_B_EN 6
`define TW_B_STA 5
`define TW_B_STO 4
`define TW_B_SI 3
`define TW_B_AA 2
`define TW_B_CR1 1
`define TW_B_CR0 0
`define TW_B_GC 0
`define TW_B_SEL 0
`define TW_B_EXT 1
`define TW_RST_CTRL 8'h00
`define TW_RST_OWN 8'hfe
`define TW_RST_SEL 2'h1
`define TW_ST_IDLE 8'hf8
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_MT_SLA_ACK 8'h18
`define TW_ST_MT_SLA_NACK 8'h20
`define TW_ST_MT_DAT_ACK 8'h28
`define TW_ST_MT_DAT_NACK 8'h30
`define TW_ST_ARB_LOST 8'h38
`define TW_ST_MR_SLA_ACK 8'h40
`define TW_ST_MR_SLA_NACK 8'h48
`define TW_ST_MR_DAT_ACK 8'h50
`define TW_ST_MR_DAT_NACK 8'h58
`define TW_ST_SR_SLA_W 8'h60
`define TW_ST_SR_GC 8'h70
`define TW_ST_SR_DAT_ACK 8'h80
`define TW_ST_SR_DAT_NACK 8'h88
`define TW_ST_GC_DAT_ACK 8'h90
`define TW_ST_GC_DAT_NACK 8'h98
`define TW_ST_SR_STOP 8'ha0
`define TW_ST_ST_SLA_R 8'ha8
`define TW_ST_ST_DAT_ACK 8'hb8
`define TW_ST_ST_DAT_NACK 8'hc0
`define TW_HALF_BASE 8
`endif

// *** include/tw_types_pkg.sv ***
// Types shared by the two-wire controller.
package tw_types_pkg;
	typedef enum logic [2:0] {
		mst_idle = 3'h0,
		mst_start = 3'h1,
		mst_run = 3'h3,
		mst_hold = 3'h2,
		mst_rstart = 3'h6,
		mst_stop = 3'h7
	} mst_t;
endpackage : tw_types_pkg

// *** design/tw_buf2.sv ***
// Small event buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tw_buf2 #(
	parameter int W = 13,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Filling side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// Draining side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [CW-1:0] count_reg;
	logic [W-1:0] ent_reg [DEPTH];
	logic [W-1:0] ent_next [DEPTH];
	logic push;
	logic pop;
	logic [CW-1:0] wr_idx;

	assign o_ready = (count_reg != CW'(DEPTH));
	assign o_valid = (count_reg != '0);
	assign o_data = ent_reg[0];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	assign wr_idx = count_reg - CW'(pop);

	// The head is always entry zero, so read data leave from a register.
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			ent_next[i] = pop ? ent_reg[(i + 1 < DEPTH) ? i + 1 : i]
				: ent_reg[i];
			if (push && (CW'(i) == wr_idx))
				ent_next[i] = i_data;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			count_reg <= '0;
		else
			count_reg <= count_reg + CW'(push) - CW'(pop);
		for (int i = 0; i < DEPTH; i++)
			ent_reg[i] <= ent_next[i];
	end
endmodule : tw_buf2
`default_nettype wire

// *** design/two_wire_serial_controller.sv ***
// Byte-oriented two-wire bus controller behind four 8-bit registers.
// Notes on behaviour
// - Reset leaves the controller disabled until software sets the enable bit.
// - Status reads give a five-bit code above three zero bits.
// - Status F8h means nothing to report; no interrupt request then.
// - Status valid in the same cycle as flag set, kept one cycle after clear.
// - Data register writable only while the interrupt flag is set.
// - Data register changes only by software writes while the interrupt flag stays set.
// - Bus level is shifted in while shifting out; data holds last byte.
// - Received addresses compare with own seven-bit address in upper bits.
// - Own-address bit 0 enables answering the general call address.
// - After each flagged event except STOP (A0h) the bus is stalled until flag clears.
// - Three rate bits set bit rate, counting clocks or external ticks when selected.
// - Start bit waits for free bus, sends START, flags status 08h.
// - After address and acknowledge, flag again with a master code.
// - Enable and rate bits are never changed by the bus logic.
// - After repeated START, address with read bit enters master receive.
// - Read bit high, write low; acknowledge low, no-acknowledge high.
// - Control register holds enable, rate, ack, start, stop, flag.
// - Status register writes select interface and rate source.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"
module two_wire_serial_controller #(
	parameter int HALF_BASE = `TW_HALF_BASE
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Special function register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Serial interrupt request and external bit-rate tick
	output logic o_si,
	input wire logic i_rate_tick,
	// Two-wire bus pins
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe_n,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n
);
	logic [7:0] ctrl_reg, own_reg, data_reg, status_reg, rdata_reg;
	logic [1:0] sel_reg;
	logic si_reg, si_prev_reg;
	logic scl_m_reg, scl_s_reg, scl_p_reg, sda_m_reg, sda_s_reg, sda_p_reg;
	tw_types_pkg::mst_t mst_reg;
	logic [10:0] timer_reg;
	logic m_low_reg, sda_oen_reg, scl_oen_reg, hold_reg, busy_reg;
	logic xfer_reg, tx_reg, ack_in_reg, addr_ph_reg, master_reg;
	logic slave_reg, read_reg, gc_reg, hit_reg, lost_reg, pend_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shifter_reg, evt_code_reg, evt_data_reg;
	logic [12:0] buf_q;
	logic buf_vld, buf_rdy;

	function automatic logic [10:0] half_count(input logic [2:0] rate);
		half_count = 11'(HALF_BASE) << rate;
	endfunction : half_count

	// Register port decode.
	wire wr_ctrl = i_sfr_wr & (i_sfr_addr == `TW_ADDR_CTRL);
	wire wr_own = i_sfr_wr & (i_sfr_addr == `TW_ADDR_OWN);
	wire wr_sel = i_sfr_wr & (i_sfr_addr == `TW_ADDR_STAT);
	wire wr_data = i_sfr_wr & (i_sfr_addr == `TW_ADDR_DATA) & si_reg;
	wire [7:0] ctrl_view = {ctrl_reg[7:4], si_reg, ctrl_reg[2:0]};
	wire [7:0] rd_mux = (i_sfr_addr == `TW_ADDR_CTRL) ? ctrl_view
		: (i_sfr_addr == `TW_ADDR_DATA) ? data_reg
		: (i_sfr_addr == `TW_ADDR_STAT) ? status_reg
		: (i_sfr_addr == `TW_ADDR_OWN) ? own_reg : 8'h00;
	wire active = ctrl_reg[`TW_B_EN] & sel_reg[`TW_B_SEL];
	wire aa = ctrl_reg[`TW_B_AA];
	wire start_request = ctrl_reg[`TW_B_STA];
	wire stop_request = ctrl_reg[`TW_B_STO];

	// Bus edges, seen only on the synchronised copies.
	wire scl_rise = scl_s_reg & ~scl_p_reg;
	wire scl_fall = ~scl_s_reg & scl_p_reg;
	wire bus_hi = scl_s_reg & scl_p_reg;
	wire start_seen = bus_hi & sda_p_reg & ~sda_s_reg;
	wire stop_seen = bus_hi & ~sda_p_reg & sda_s_reg;

	// Bit timing: one step per clock, or per external tick when selected.
	wire [2:0] rate = {ctrl_reg[`TW_B_CR2], ctrl_reg[`TW_B_CR1],
		ctrl_reg[`TW_B_CR0]};
	wire [10:0] half = half_count(rate);
	wire step = sel_reg[`TW_B_EXT] ? i_rate_tick : 1'b1;
	wire cnt_en = step & (m_low_reg | scl_s_reg);
	wire tdone = cnt_en & (timer_reg == half - 11'd1);

	// Byte engine decode.
	wire fall8 = scl_fall & xfer_reg & (cnt_reg == 4'd8);
	wire done = scl_fall & xfer_reg & (cnt_reg == 4'd9);
	wire match = (shifter_reg[7:1] == own_reg[7:1]);
	wire gcm = (shifter_reg == 8'h00) & own_reg[`TW_B_GC];
	wire slave_ad = addr_ph_reg & ~master_reg;
	wire ack_out = slave_ad ? aa & (match | gcm) : aa;
	wire ack = ~ack_in_reg;
	wire lost_now = scl_rise & xfer_reg & tx_reg & master_reg
		& (cnt_reg < 4'd8) & sda_oen_reg & ~sda_s_reg;
	wire notify = done & (master_reg | lost_reg | slave_reg | hit_reg);
	wire start_go = (mst_reg == tw_types_pkg::mst_idle) & active & start_request
		& ~busy_reg & ~hold_reg;
	wire start_ev = (mst_reg == tw_types_pkg::mst_start) & tdone;
	wire a0_ev = stop_seen & slave_reg & ~read_reg;
	wire drain_ok = ~si_reg & ~si_prev_reg;
	wire pop = buf_vld & drain_ok;
	wire resume = hold_reg & drain_ok & ~pend_reg & ~buf_vld;
	wire m_stop = master_reg & stop_request;
	wire m_rst = master_reg & start_request & ~stop_request;
	wire resume_run = resume & (master_reg ? ~stop_request & ~start_request : slave_reg);
	wire next_tx = master_reg ? (addr_ph_reg | ~read_reg) : read_reg;
	wire stop_end = (mst_reg == tw_types_pkg::mst_stop) & tdone & ~m_low_reg;

	wire [7:0] m_code = addr_ph_reg
		? (shifter_reg[0] ? (ack ? `TW_ST_MR_SLA_ACK : `TW_ST_MR_SLA_NACK)
		: (ack ? `TW_ST_MT_SLA_ACK : `TW_ST_MT_SLA_NACK))
		: read_reg ? (ack ? `TW_ST_MR_DAT_ACK : `TW_ST_MR_DAT_NACK)
		: (ack ? `TW_ST_MT_DAT_ACK : `TW_ST_MT_DAT_NACK);
	wire [7:0] s_code = addr_ph_reg
		? (shifter_reg[0] ? `TW_ST_ST_SLA_R
		: gc_reg ? `TW_ST_SR_GC : `TW_ST_SR_SLA_W)
		: read_reg ? (ack ? `TW_ST_ST_DAT_ACK : `TW_ST_ST_DAT_NACK)
		: gc_reg ? (ack ? `TW_ST_GC_DAT_ACK : `TW_ST_GC_DAT_NACK)
		: (ack ? `TW_ST_SR_DAT_ACK : `TW_ST_SR_DAT_NACK);
	wire [7:0] done_code = lost_reg ? `TW_ST_ARB_LOST
		: master_reg ? m_code : s_code;

	assign o_sfr_rdata = rdata_reg;
	assign o_si = si_reg;
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_scl_oe_n = scl_oen_reg;
	assign o_sda_oe_n = sda_oen_reg;

	// Three flip-flops in front of every bus pin; edges use the last two.
	always_ff @(posedge i_clk)
	begin
		{scl_m_reg, scl_s_reg, scl_p_reg} <= {i_scl, scl_m_reg, scl_s_reg};
		{sda_m_reg, sda_s_reg, sda_p_reg} <= {i_sda, sda_m_reg, sda_s_reg};
	end

	// Control, own address, select and read data.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ctrl_reg <= `TW_RST_CTRL;
			own_reg <= `TW_RST_OWN;
			sel_reg <= `TW_RST_SEL;
			rdata_reg <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= i_sfr_wdata;
			else if (stop_end)
				ctrl_reg[`TW_B_STO] <= 1'b0;
			if (wr_own)
				own_reg <= i_sfr_wdata;
			if (wr_sel)
				sel_reg <= i_sfr_wdata[1:0];
			if (i_sfr_rd)
				rdata_reg <= rd_mux;
		end
	end

	// Flag, status and data; a new event wins over a clear.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			si_reg <= 1'b0;
			si_prev_reg <= 1'b0;
			status_reg <= `TW_ST_IDLE;
			data_reg <= 8'h00;
		end
		else
		begin
			si_prev_reg <= si_reg;
			if (pop)
				si_reg <= 1'b1;
			else if (wr_ctrl & ~i_sfr_wdata[`TW_B_SI])
				si_reg <= 1'b0;
			if (pop)
				status_reg <= {buf_q[12:8], 3'b000};
			else if (~si_reg & ~si_prev_reg)
				status_reg <= `TW_ST_IDLE;
			if (pop)
				data_reg <= buf_q[7:0];
			else if (wr_data)
				data_reg <= i_sfr_wdata;
		end
	end

	// Events wait here until the buffer takes them.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			pend_reg <= 1'b0;
		else if (notify | start_ev | a0_ev)
			pend_reg <= 1'b1;
		else if (buf_rdy)
			pend_reg <= 1'b0;
		if (start_ev)
			evt_code_reg <= master_reg ? `TW_ST_RSTART : `TW_ST_START;
		else if (a0_ev)
			evt_code_reg <= `TW_ST_SR_STOP;
		else if (notify)
			evt_code_reg <= done_code;
		evt_data_reg <= notify ? shifter_reg : data_reg;
	end

	tw_buf2 #(
		.W(13),
		.DEPTH(2)
	) u_buf (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_valid(pend_reg),
		.o_ready(buf_rdy),
		.i_data({evt_code_reg[7:3], evt_data_reg}),
		.o_valid(buf_vld),
		.i_ready(drain_ok),
		.o_data(buf_q)
	);

	// Half-period timer for the master clock.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || tdone || mst_reg == tw_types_pkg::mst_idle
			|| mst_reg == tw_types_pkg::mst_hold)
			timer_reg <= 11'd0;
		else if (cnt_en)
			timer_reg <= timer_reg + 11'd1;
	end

	// Master sequencer; it releases the bus when the block is disabled.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !active)
		begin
			mst_reg <= tw_types_pkg::mst_idle;
			m_low_reg <= 1'b0;
		end
		else
			case (mst_reg)
			tw_types_pkg::mst_idle:
				if (start_go)
					mst_reg <= tw_types_pkg::mst_start;
			tw_types_pkg::mst_start:
				if (tdone)
				begin
					m_low_reg <= 1'b1;
					mst_reg <= tw_types_pkg::mst_hold;
				end
			tw_types_pkg::mst_run:
				if (lost_now)
				begin
					m_low_reg <= 1'b0;
					mst_reg <= tw_types_pkg::mst_idle;
				end
				else if (done)
					mst_reg <= tw_types_pkg::mst_hold;
				else if (tdone)
					m_low_reg <= ~m_low_reg;
			tw_types_pkg::mst_hold:
				if (resume)
					mst_reg <= m_stop ? tw_types_pkg::mst_stop
						: m_rst ? tw_types_pkg::mst_rstart
						: tw_types_pkg::mst_run;
			tw_types_pkg::mst_rstart:
				if (tdone && m_low_reg)
					m_low_reg <= 1'b0;
				else if (tdone)
					mst_reg <= tw_types_pkg::mst_start;
			tw_types_pkg::mst_stop:
				if (tdone && m_low_reg)
					m_low_reg <= 1'b0;
				else if (tdone)
					mst_reg <= tw_types_pkg::mst_idle;
			default:
				mst_reg <= tw_types_pkg::mst_idle;
			endcase
	end

	// Byte engine shared by master and slave roles.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !active || stop_seen)
		begin
			{xfer_reg, slave_reg, master_reg, lost_reg} <= 4'h0;
			{tx_reg, addr_ph_reg, hit_reg, gc_reg} <= 4'h0;
			cnt_reg <= 4'd0;
		end
		else if (start_ev)
		begin
			master_reg <= 1'b1;
			addr_ph_reg <= 1'b1;
			xfer_reg <= 1'b0;
		end
		else if (start_seen && !master_reg)
		begin
			{xfer_reg, addr_ph_reg} <= 2'h3;
			{tx_reg, slave_reg, hit_reg, gc_reg} <= 4'h0;
			cnt_reg <= 4'd0;
		end
		else if (resume_run)
		begin
			xfer_reg <= 1'b1;
			cnt_reg <= 4'd0;
			shifter_reg <= data_reg;
			tx_reg <= next_tx;
		end
		else
		begin
			if (scl_rise && xfer_reg)
			begin
				cnt_reg <= cnt_reg + 4'd1;
				if (cnt_reg < 4'd8)
					shifter_reg <= {shifter_reg[6:0], sda_s_reg};
				else
					ack_in_reg <= sda_s_reg;
			end
			if (lost_now)
				{master_reg, lost_reg, tx_reg} <= 3'h2;
			if (fall8 && slave_ad)
			begin
				hit_reg <= aa & (match | gcm);
				gc_reg <= gcm;
			end
			if (done)
			begin
				xfer_reg <= 1'b0;
				addr_ph_reg <= 1'b0;
				lost_reg <= 1'b0;
				if (addr_ph_reg)
					read_reg <= shifter_reg[0];
				if (slave_ad && hit_reg)
					slave_reg <= 1'b1;
				else if (slave_reg && !ack)
					slave_reg <= 1'b0;
			end
		end
	end

	// Data line drive: oe_n low pulls the line low.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !active || lost_now)
			sda_oen_reg <= 1'b1;
		else if (start_go || ((mst_reg == tw_types_pkg::mst_rstart)
			&& tdone && !m_low_reg))
			sda_oen_reg <= 1'b0;
		else if (resume)
			sda_oen_reg <= m_stop ? 1'b0
				: ~(resume_run & next_tx & ~data_reg[7]);
		else if (stop_end)
			sda_oen_reg <= 1'b1;
		else if (scl_fall && xfer_reg)
		begin
			if (cnt_reg == 4'd8)
				sda_oen_reg <= ~(~tx_reg & ack_out);
			else if (cnt_reg == 4'd9)
				sda_oen_reg <= 1'b1;
			else if (cnt_reg != 4'd0)
				sda_oen_reg <= ~(tx_reg & ~shifter_reg[7]);
		end
	end

	// Clock stretch while an event is pending service.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !active)
			{hold_reg, busy_reg, scl_oen_reg} <= 3'h1;
		else
		begin
			if (notify || start_ev)
				hold_reg <= 1'b1;
			else if (resume)
				hold_reg <= 1'b0;
			if (start_seen)
				busy_reg <= 1'b1;
			else if (stop_seen)
				busy_reg <= 1'b0;
			scl_oen_reg <= ~(m_low_reg | hold_reg);
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence stop_leave;
		(mst_reg == tw_types_pkg::mst_stop) ##1
			(mst_reg == tw_types_pkg::mst_idle);
	endsequence
	sequence flag_cleared;
		$fell(si_reg) && !pop;
	endsequence

	AST_RESET_DISABLED: assert property (
		$past(i_srst) && !$past(wr_ctrl) |-> !ctrl_reg[`TW_B_EN])
		else $error("Controller enabled right after reset.");
	AST_STATUS_LOW_ZERO: assert property (
		status_reg[2:0] == 3'b000)
		else $error("Status low bits not zero.");
	AST_IDLE_NO_FLAG: assert property (
		status_reg == `TW_ST_IDLE |-> !si_reg)
		else $error("Flag set while status shows idle.");
	AST_STATUS_HELD: assert property (
		flag_cleared |-> $stable(status_reg) ##1 $stable(status_reg)
			##1 (status_reg == `TW_ST_IDLE || si_reg))
		else $error("Status not held one cycle after flag clear.");
	AST_FLAG_STATUS: assert property (
		$rose(si_reg) |-> status_reg != `TW_ST_IDLE)
		else $error("No valid status with flag set.");
	AST_DATA_STABLE: assert property (
		si_reg && $past(si_reg) && !$past(wr_data) |-> $stable(data_reg))
		else $error("Data register changed while flag set.");
	AST_BUS_STALLED: assert property (
		si_reg && hold_reg |-> ##1 !o_scl_oe_n)
		else $error("Clock line released while flag set.");
	AST_RATE_KEPT: assert property (
		!$past(wr_ctrl) |-> {ctrl_reg[7:6], ctrl_reg[1:0]}
			== $past({ctrl_reg[7:6], ctrl_reg[1:0]}))
		else $error("Enable or rate bits changed by hardware.");
	AST_START_CODE: assert property (
		start_ev |=> pend_reg && (evt_code_reg == `TW_ST_START
			|| evt_code_reg == `TW_ST_RSTART))
		else $error("START not reported with its code.");
	AST_STOP_CLEARS: assert property (
		stop_leave |-> !stop_request || $past(wr_ctrl))
		else $error("Stop bit not cleared after STOP.");
	AST_GC_GATED: assert property (
		gc_reg && hit_reg |-> own_reg[`TW_B_GC])
		else $error("General call answered while disabled.");
endmodule : two_wire_serial_controller
`default_nettype wire

// *** verif/bus_peer_model.sv ***
// Behavioural two-wire peer: an addressed target and a slow bus master.
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model #(
	parameter logic [6:0] TGT = 7'h52,
	parameter logic [7:0] RD_BYTE = 8'hc6
) (
	// Bus levels
	input wire logic i_scl,
	input wire logic i_sda,
	// Pull-downs of this peer
	output logic o_scl_low,
	output logic o_sda_low
);
	logic [7:0] sh = 8'h00;
	logic [7:0] got = 8'h00;
	int cnt = 0;
	bit first = 0;
	bit sel = 0;
	bit rd = 0;
	logic t_low = 1'b0;
	logic m_sda = 1'b1;
	assign o_sda_low = t_low | ~m_sda;
	initial o_scl_low = 1'b0;
	always @(negedge i_sda)
		if (i_scl)
		begin
			cnt = 0;
			first = 1;
			sel = 0;
		end
	always @(posedge i_sda)
		if (i_scl)
			sel = 0;
	always @(posedge i_scl)
	begin
		if (cnt < 8)
			sh = {sh[6:0], i_sda};
		cnt++;
	end
	// Changes follow the falling clock after a hold time, as a real part.
	always @(negedge i_scl)
		if (cnt == 8)
		begin
			got = sh;
			if (first)
			begin
				sel = (sh[7:1] == TGT);
				rd = sh[0];
			end
			t_low <= #2 sel & (first | ~rd);
			first = 0;
		end
		else if (cnt == 9)
		begin
			cnt = 0;
			t_low <= #2 sel & rd & ~RD_BYTE[7];
		end
		else if (sel & rd & cnt > 0)
			t_low <= #2 ~RD_BYTE[7 - cnt];
	// One address byte then STOP, clock period 64 ns; stretching honoured.
	task automatic frame(input logic [7:0] b, output logic ack);
		int i;
		int j;
		m_sda = 1'b0;
		#32 o_scl_low = 1'b1;
		for (i = 9; i >= 0; i--)
		begin
			#8 m_sda = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : b[i - 2];
			#24 o_scl_low = 1'b0;
			for (j = 0; j < 4000 && !i_scl; j++)
				#8;
			#32;
			if (i == 1)
				ack = i_sda;
			if (i > 0)
				o_scl_low = 1'b1;
		end
		m_sda = 1'b1;
	endtask : frame
endmodule : bus_peer_model
`default_nettype wire

// *** verif/two_wire_serial_controller_tb_top.sv ***
// Self-checking bench for the two-wire controller as master and as slave.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"
module two_wire_serial_controller_tb_top;
	localparam logic [6:0] TGT = 7'h52;
	localparam logic [7:0] RD_BYTE = 8'hc6;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] i_sfr_addr = 8'h00;
	logic i_sfr_wr = 1'b0;
	logic i_sfr_rd = 1'b0;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic i_rate_tick = 1'b0;
	wire logic [7:0] o_sfr_rdata;
	wire logic o_si;
	wire logic o_scl_oe_n;
	wire logic o_sda_oe_n;
	wire logic peer_scl_low;
	wire logic peer_sda_low;
	wire logic scl_w;
	wire logic sda_w;
	int fails = 0;
	int tests_run = 0;
	logic [15:0] lfsr = 16'he7d5;
	logic [15:0] tick_sr = 16'he7d5;
	// Both lines are open drain with a pull-up.
	assign scl_w = o_scl_oe_n & ~peer_scl_low;
	assign sda_w = o_sda_oe_n & ~peer_sda_low;
	two_wire_serial_controller #(.HALF_BASE(4)) two_wire_serial_controller_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
		.o_sfr_rdata(o_sfr_rdata), .o_si(o_si), .i_rate_tick(i_rate_tick),
		.i_scl(scl_w), .o_scl(), .o_scl_oe_n(o_scl_oe_n),
		.i_sda(sda_w), .o_sda(), .o_sda_oe_n(o_sda_oe_n)
	);
	bus_peer_model #(.TGT(TGT), .RD_BYTE(RD_BYTE)) bus_peer_model_i (
		.i_scl(scl_w), .i_sda(sda_w),
		.o_scl_low(peer_scl_low), .o_sda_low(peer_sda_low)
	);
	initial
		forever #2.5 i_clk = ~i_clk;
	// The external tick advances every clock so that it never sticks low.
	always @(posedge i_clk)
	begin
		tick_sr <= #1 lfsr_next(tick_sr);
		i_rate_tick <= #1 tick_sr[0];
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [7:0] ctl(input logic [2:0] r,
		input logic [7:0] b);
		return b | {r[2], 5'h00, r[1:0]};
	endfunction : ctl
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(posedge i_clk) #1;
		i_sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk) #1;
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(posedge i_clk) #1;
		i_sfr_rd = 1'b0;
		d = o_sfr_rdata;
	endtask : rd
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(n, d, e);
	endtask : rchk
	task automatic si_exp(input string n, input logic e, input int lim);
		int i;
		for (i = 0; i < lim && o_si !== 1'b1; i++)
			@(posedge i_clk) #1;
		chk(n, {7'h00, o_si}, {7'h00, e});
	endtask : si_exp
	task automatic step(input logic [2:0] r, input logic [7:0] c,
		input logic [7:0] st);
		wr(`TW_ADDR_CTRL, ctl(r, c));
		si_exp("si", 1'b1, 20000);
		rchk("status", `TW_ADDR_STAT, st);
	endtask : step
	initial
	begin
		#400_000;
		fails++;
		conclude();
	end
	initial
	begin
		logic [7:0] d;
		logic [7:0] b;
		logic [2:0] r;
		logic [6:0] oa;
		logic ack;
		int i;
		int p;
		repeat (10) @(posedge i_clk);
		#1 i_srst = 1'b0;
		chk("oe_n", {6'h00, o_scl_oe_n, o_sda_oe_n}, 8'h03);
		rchk("ctrl", `TW_ADDR_CTRL, `TW_RST_CTRL);
		rchk("status", `TW_ADDR_STAT, `TW_ST_IDLE);
		rchk("own", `TW_ADDR_OWN, `TW_RST_OWN);
		rchk("unmapped", 8'h90, 8'h00);
		rd(`TW_ADDR_DATA, d);
		wr(`TW_ADDR_DATA, ~d);
		rchk("data idle", `TW_ADDR_DATA, d);
		wr(`TW_ADDR_STAT, 8'h00);
		wr(`TW_ADDR_CTRL, 8'h64);
		si_exp("si deselected", 1'b0, 300);
		wr(`TW_ADDR_CTRL, 8'h00);
		for (p = 0; p < 2; p++)
		begin
			wr(`TW_ADDR_STAT, {6'h00, p == 1, 1'b1});
			lfsr = lfsr_next(lfsr);
			r = {1'b0, lfsr[1:0]};
			b = lfsr[15:8];
			wr(`TW_ADDR_CTRL, ctl(r, 8'h44));
			step(r, 8'h64, `TW_ST_START);
			repeat (20) @(posedge i_clk);
			chk("scl held", {7'h00, scl_w}, 8'h00);
			wr(`TW_ADDR_DATA, {~TGT, 1'b0});
			rchk("data", `TW_ADDR_DATA, {~TGT, 1'b0});
			step(r, 8'h44, `TW_ST_MT_SLA_NACK);
			rchk("ctrl", `TW_ADDR_CTRL, ctl(r, 8'h4c));
			step(r, 8'h64, `TW_ST_RSTART);
			wr(`TW_ADDR_DATA, {TGT, 1'b0});
			step(r, 8'h44, `TW_ST_MT_SLA_ACK);
			chk("wire addr", bus_peer_model_i.got, {TGT, 1'b0});
			wr(`TW_ADDR_DATA, b);
			step(r, 8'h44, `TW_ST_MT_DAT_ACK);
			chk("wire data", bus_peer_model_i.got, b);
			rchk("data", `TW_ADDR_DATA, b);
			step(r, 8'h64, `TW_ST_RSTART);
			wr(`TW_ADDR_DATA, {TGT, 1'b1});
			step(r, 8'h44, `TW_ST_MR_SLA_ACK);
			step(r, 8'h44, `TW_ST_MR_DAT_ACK);
			rchk("rx data", `TW_ADDR_DATA, RD_BYTE);
			wr(`TW_ADDR_CTRL, ctl(r, 8'h54));
			for (i = 0; i < 400; i++)
			begin
				rd(`TW_ADDR_CTRL, d);
				if (d[4] === 1'b0)
					break;
			end
			chk("stop self clear", d, ctl(r, 8'h44));
			rchk("status", `TW_ADDR_STAT, `TW_ST_IDLE);
			chk("bus free", {6'h00, scl_w, sda_w}, 8'h03);
		end
		// Slave cases: own address, general call on, general call off.
		lfsr = lfsr_next(lfsr);
		oa = {2'b11, lfsr[5:1]};
		for (i = 0; i < 3; i++)
		begin
			wr(`TW_ADDR_OWN, {oa, i != 2});
			rchk("own", `TW_ADDR_OWN, {oa, i != 2});
			wr(`TW_ADDR_CTRL, 8'h44);
			b = (i == 0) ? {oa, 1'b0} : 8'h00;
			fork
				bus_peer_model_i.frame(b, ack);
				begin
					si_exp("slave si", i != 2, 3000);
					if (i != 2)
						rchk("slave status", `TW_ADDR_STAT,
							(i == 0) ? `TW_ST_SR_SLA_W : `TW_ST_SR_GC);
					wr(`TW_ADDR_CTRL, 8'h44);
				end
			join
			chk("slave ack", {7'h00, ack}, {7'h00, i == 2});
			repeat (20) @(posedge i_clk);
			#1;
			chk("stop si", {7'h00, o_si}, {7'h00, i != 2});
			wr(`TW_ADDR_CTRL, 8'h44);
			rchk("status held", `TW_ADDR_STAT,
				(i != 2) ? `TW_ST_SR_STOP : `TW_ST_IDLE);
			rchk("status", `TW_ADDR_STAT, `TW_ST_IDLE);
		end
		conclude();
	end
endmodule : two_wire_serial_controller_tb_top
`default_nettype wire
